// >>> common/fpa_pkg.sv
/*
 * shared constants, types and helpers of the feeder protection auxiliary logic.
 * assumes a single 250 MHz core clock and scaled measurement words.
 */
package fpa_pkg;

	// ****************************************************************
	// timing
	// ****************************************************************
	localparam int CLK_MHZ     = 250;
	localparam int TICK_MS     = 100;
	localparam int TICK_CYCLES = CLK_MHZ * 1000 * TICK_MS;

	// ****************************************************************
	// sizes and setting limits
	// ****************************************************************
	localparam int N_PROT  = 8;
	localparam int N_STAGE = 3;
	localparam int TW      = 10;

	localparam logic [TW-1:0] DELAY_MAX_TICKS = 10'h258;
	localparam logic [15:0]   SS_THR_MIN      = 16'h01f4;
	localparam logic [15:0]   SS_THR_MAX      = 16'h4e20;
	localparam logic [15:0]   V1_THR_MIN      = 16'h0000;
	localparam logic [15:0]   V1_THR_MAX      = 16'h005a;
	localparam logic [15:0]   V0_THR_MIN      = 16'h000a;
	localparam logic [15:0]   V0_THR_MAX      = 16'h0082;
	localparam logic [7:0]    PCT_SCALE       = 8'h64;
	localparam logic [15:0]   ZERO16          = 16'h0000;

	// ****************************************************************
	// types
	// ****************************************************************
	typedef enum logic {FPA_COLD_PICKUP, FPA_COLD_CURVE} fpa_cold_mode_t;
	typedef enum logic {FPA_CURVE_DEFINITE, FPA_CURVE_INVERSE} fpa_curve_t;
	typedef enum logic {FPA_COLD_IDLE, FPA_COLD_ACTIVE} fpa_cold_state_t;

	typedef struct packed {
		logic relay;
		logic virt;
	} fpa_route_t;

	// currents in amperes, voltages in hundredths of nominal_voltage
	typedef struct packed {
		logic [15:0] i_a;
		logic [15:0] i_b;
		logic [15:0] i_c;
		logic [15:0] i_res;
		logic [15:0] i1;
		logic [15:0] i2;
		logic [15:0] v1;
		logic [15:0] v0;
	} fpa_meas_t;

	function automatic logic [15:0] clamp16(input logic [15:0] v, input logic [15:0] lo,
			input logic [15:0] hi);
		clamp16 = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	function automatic logic [15:0] max3(input logic [15:0] a, input logic [15:0] b,
			input logic [15:0] c);
		logic [15:0] m;
		m = (a > b) ? a : b;
		max3 = (m > c) ? m : c;
	endfunction

endpackage : fpa_pkg

// >>> rtl/fpa_tick_gen.sv
/*
 * free-running timebase that issues one-cycle ticks.
 * assumes one clock; the period is a parameter so that simulation can shorten it.
 */
module fpa_tick_gen #(
	parameter int TICK_CYCLES = fpa_pkg::TICK_CYCLES
) (
	input  wire logic core_clk,
	input  wire logic rst_b,
	output logic      tick
);

	logic [31:0] cnt_reg;

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= 32'h0000_0000;
			tick    <= 1'b0;
		end else if (cnt_reg >= 32'(TICK_CYCLES - 1)) begin
			cnt_reg <= 32'h0000_0000;
			tick    <= 1'b1;
		end else begin
			cnt_reg <= cnt_reg + 32'h0000_0001;
			tick    <= 1'b0;
		end
	end

endmodule // fpa_tick_gen

// >>> rtl/fpa_delay_timer.sv
/*
 * definite-time delay counted in ticks.
 * assumes a one-cycle tick from the shared timebase; run low clears it at once.
 */
module fpa_delay_timer (
	input  wire logic                  core_clk,
	input  wire logic                  rst_b,
	input  wire logic                  tick,
	input  wire logic                  run,
	input  wire logic [fpa_pkg::TW-1:0] limit,
	output logic                       done
);

	logic [fpa_pkg::TW-1:0] cnt_reg;

	// a limit of zero expires on the cycle after run rises
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cnt_reg <= '0;
			done    <= 1'b0;
		end else if (!run) begin
			cnt_reg <= '0;
			done    <= 1'b0;
		end else if (cnt_reg >= limit) begin
			done <= 1'b1;
		end else if (tick) begin
			cnt_reg <= cnt_reg + 1'b1;
		end
	end

endmodule // fpa_delay_timer

// >>> rtl/fpa_prot_aux.sv
/*
 * auxiliary protection supervision: cold load pickup, breaker failure,
 * shot skip and broken-conductor detection.
 * assumes measurement words and breaker status come from logic on core_clk.
 */
// What this block does
// RULE1: cold load pickup: pickup override or curve mode
// RULE2: curve mode picks definite or inverse time
// RULE3: cold load pickup has enable; idle when disabled
// RULE4: open-to-closed breaker starts timed interval
// RULE5: blocked: delay zero, keep returning start stage
// RULE6: breaker failure uses polyphase and single-phase elements
// RULE7: breaker failure enable and monitored-protection mask
// RULE8: masked protection trip starts failure timer
// RULE9: trips still present at expiry drive outputs
// RULE10: heavy fault trips instantly and skips reclose stages
// RULE11: shot skip off leaves reclosing untouched
// RULE12: skip thresholds 500 to 20000 A, both faults
// RULE13: skip count 0 to 3, zero skips none
// RULE14: count N omits first N stages in order
// RULE15: protections subject to shot skip are selectable
// RULE16: ratio above threshold drives relay/virtual outputs
// RULE17: inhibited below discrimination, active above overcurrent
// RULE18: broken-conductor delay 0 to 60 s, 0.1 s
// RULE19: low positive-sequence voltage blocks operation
// RULE20: high zero-sequence voltage blocks operation
// RULE21: all timers count a fixed clock-derived tick
// RULE22: front end supplies strobed measurements and breaker state
module fpa_prot_aux #(
	parameter int TICK_CYCLES = fpa_pkg::TICK_CYCLES
) (
	input  wire logic                           core_clk,
	input  wire logic                           rst_b,
	input  wire fpa_pkg::fpa_meas_t             meas,
	input  wire logic                           meas_valid,
	input  wire logic                           brk_closed,
	input  wire logic [fpa_pkg::N_PROT-1:0]     prot_trip,
	input  wire logic                           cold_load_pickup_en,
	input  wire logic                           cold_load_pickup_block,
	input  wire fpa_pkg::fpa_cold_mode_t        cold_load_pickup_mode,
	input  wire fpa_pkg::fpa_curve_t            cold_load_pickup_curve,
	input  wire logic [15:0]                    cold_load_pickup_level,
	input  wire logic [fpa_pkg::TW-1:0]         cold_load_pickup_duration,
	output logic                                cold_load_pickup_active,
	output logic                                cold_load_pickup_override,
	output logic [15:0]                         cold_load_pickup_level_out,
	output logic                                cold_load_pickup_curve_sel,
	output fpa_pkg::fpa_curve_t                 cold_load_pickup_curve_out,
	output logic [fpa_pkg::TW-1:0]              cold_load_pickup_delay,
	output logic                                cold_load_pickup_stage_reset,
	input  wire logic                           bf_en,
	input  wire logic [fpa_pkg::N_PROT-1:0]     bf_mask,
	input  wire logic [15:0]                    bf_phase_thr,
	input  wire logic [15:0]                    bf_ground_thr,
	input  wire logic [fpa_pkg::TW-1:0]         bf_time,
	input  wire fpa_pkg::fpa_route_t            bf_route,
	output fpa_pkg::fpa_route_t                 bf_out,
	input  wire logic                           shot_skip_en,
	input  wire logic [fpa_pkg::N_PROT-1:0]     shot_skip_mask,
	input  wire logic [15:0]                    shot_skip_thr_pp,
	input  wire logic [15:0]                    shot_skip_thr_pg,
	input  wire logic [1:0]                     shot_skip_count,
	input  wire logic                           seq_restart,
	output logic                                shot_skip_trip,
	output logic [fpa_pkg::N_STAGE-1:0]         shot_skip_stages,
	input  wire logic                           bc_en,
	input  wire logic [15:0]                    bc_oc_thr,
	input  wire logic [15:0]                    bc_disc_thr,
	input  wire logic [7:0]                     bc_ratio_pct,
	input  wire logic [fpa_pkg::TW-1:0]         bc_delay,
	input  wire logic [15:0]                    bc_v1_thr,
	input  wire logic [15:0]                    bc_v0_thr,
	input  wire fpa_pkg::fpa_route_t            bc_route,
	output fpa_pkg::fpa_route_t                 bc_out
);

	// ****************************************************************
	// timebase and measurement capture
	// ****************************************************************
	logic                   tick;
	fpa_pkg::fpa_meas_t     meas_reg;
	logic                   brk_closed_reg;

	fpa_tick_gen #(
		.TICK_CYCLES (TICK_CYCLES)
	) u_tick (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.tick     (tick)                                  // RULE21
	);

	// words are only trusted when strobed; between strobes the last set holds
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			meas_reg <= '0;
		end else if (meas_valid) begin
			meas_reg <= meas;                                 // RULE22
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			brk_closed_reg <= 1'b0;
		end else begin
			brk_closed_reg <= brk_closed;
		end
	end

	logic        brk_close_edge;
	logic [15:0] i_phase_max;

	assign brk_close_edge = brk_closed && !brk_closed_reg;
	assign i_phase_max    = fpa_pkg::max3(meas_reg.i_a, meas_reg.i_b, meas_reg.i_c);

	// ****************************************************************
	// cold load pickup
	// ****************************************************************
	// settings above the longest delay clamp rather than wrap
	function automatic logic [fpa_pkg::TW-1:0] to_ticks(input logic [fpa_pkg::TW-1:0] d);
		logic [15:0] c;
		c = fpa_pkg::clamp16(16'(d), fpa_pkg::ZERO16, 16'(fpa_pkg::DELAY_MAX_TICKS));
		to_ticks = c[fpa_pkg::TW-1:0];
	endfunction

	fpa_pkg::fpa_cold_state_t cold_state_reg;
	logic                     cold_done;
	logic                     cold_run;
	logic [fpa_pkg::TW-1:0]   cold_limit;

	assign cold_run   = (cold_state_reg == fpa_pkg::FPA_COLD_ACTIVE);
	assign cold_limit = to_ticks(cold_load_pickup_duration);

	fpa_delay_timer u_cold_timer (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.tick     (tick),
		.run      (cold_run),
		.limit    (cold_limit),
		.done     (cold_done)                             // RULE4
	);

	// an open breaker or a disable ends the interval early
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cold_state_reg <= fpa_pkg::FPA_COLD_IDLE;
		end else begin
			unique case (cold_state_reg)
				fpa_pkg::FPA_COLD_IDLE: begin
					if (cold_load_pickup_en && !cold_load_pickup_block && brk_close_edge) begin
						cold_state_reg <= fpa_pkg::FPA_COLD_ACTIVE;  // RULE4
					end
				end
				fpa_pkg::FPA_COLD_ACTIVE: begin
					if (!cold_load_pickup_en || cold_load_pickup_block || cold_done ||
						!brk_closed) begin
						cold_state_reg <= fpa_pkg::FPA_COLD_IDLE;    // RULE3
					end
				end
			endcase
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cold_load_pickup_active    <= 1'b0;
			cold_load_pickup_override  <= 1'b0;
			cold_load_pickup_level_out <= 16'h0000;
			cold_load_pickup_curve_sel <= 1'b0;
			cold_load_pickup_curve_out <= fpa_pkg::FPA_CURVE_DEFINITE;
		end else begin
			cold_load_pickup_active    <= cold_run && cold_load_pickup_en;  // RULE3
			cold_load_pickup_override  <= cold_run && cold_load_pickup_en &&
				cold_load_pickup_mode == fpa_pkg::FPA_COLD_PICKUP;           // RULE1
			cold_load_pickup_level_out <= cold_load_pickup_level;           // RULE1
			cold_load_pickup_curve_sel <= cold_run && cold_load_pickup_en &&
				cold_load_pickup_mode == fpa_pkg::FPA_COLD_CURVE;            // RULE1
			cold_load_pickup_curve_out <= cold_load_pickup_curve;          // RULE2
		end
	end

	// blocked: delay forced to zero and start stage requested every cycle
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			cold_load_pickup_delay       <= '0;
			cold_load_pickup_stage_reset <= 1'b0;
		end else begin
			cold_load_pickup_delay       <= cold_load_pickup_block ? '0 : cold_limit;  // RULE5
			cold_load_pickup_stage_reset <= cold_load_pickup_block;                   // RULE5
		end
	end

	// ****************************************************************
	// breaker failure
	// ****************************************************************
	logic                   bf_poly;
	logic                   bf_single;
	logic                   bf_started;
	logic                   bf_done;
	logic [fpa_pkg::TW-1:0] bf_limit;
	logic [1:0]             bf_phases_hi;

	// two or more phases above setting is treated as a polyphase fault
	assign bf_phases_hi = 2'(meas_reg.i_a >= bf_phase_thr) + 2'(meas_reg.i_b >= bf_phase_thr) +
		2'(meas_reg.i_c >= bf_phase_thr);
	assign bf_poly      = bf_phases_hi >= 2'h2;                                  // RULE6
	assign bf_single    = meas_reg.i_res >= bf_ground_thr;                      // RULE6
	assign bf_started   = bf_en && |(prot_trip & bf_mask);                      // RULE7 RULE8
	assign bf_limit     = to_ticks(bf_time);

	fpa_delay_timer u_bf_timer (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.tick     (tick),
		.run      (bf_started),
		.limit    (bf_limit),
		.done     (bf_done)                               // RULE8
	);

	// drops as soon as the trips drop out or current stops
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bf_out <= '0;
		end else begin
			bf_out.relay <= bf_done && bf_started && (bf_poly || bf_single) && bf_route.relay;  // RULE9
			bf_out.virt  <= bf_done && bf_started && (bf_poly || bf_single) && bf_route.virt;   // RULE9
		end
	end

	// ****************************************************************
	// shot skip
	// ****************************************************************
	logic [15:0] ss_thr_pp;
	logic [15:0] ss_thr_pg;
	logic        ss_fire;

	assign ss_thr_pp = fpa_pkg::clamp16(shot_skip_thr_pp, fpa_pkg::SS_THR_MIN,
		fpa_pkg::SS_THR_MAX);                                                     // RULE12
	assign ss_thr_pg = fpa_pkg::clamp16(shot_skip_thr_pg, fpa_pkg::SS_THR_MIN,
		fpa_pkg::SS_THR_MAX);                                                     // RULE12
	assign ss_fire   = shot_skip_en && |(prot_trip & shot_skip_mask) &&
		(i_phase_max >= ss_thr_pp || meas_reg.i_res >= ss_thr_pg);              // RULE10 RULE15

	function automatic logic [fpa_pkg::N_STAGE-1:0] skip_map(input logic [1:0] n);
		logic [fpa_pkg::N_STAGE-1:0] m;
		m = '0;
		for (int k = 0; k < fpa_pkg::N_STAGE; k++) begin
			m[k] = (k < int'(n));
		end
		skip_map = m;
	endfunction

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			shot_skip_trip <= 1'b0;
		end else begin
			shot_skip_trip <= ss_fire;                       // RULE10
		end
	end

	// a new fire in the restart cycle wins, so the skip is not lost
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			shot_skip_stages <= '0;
		end else if (!shot_skip_en) begin
			shot_skip_stages <= '0;                          // RULE11
		end else if (ss_fire) begin
			shot_skip_stages <= skip_map(shot_skip_count);   // RULE13 RULE14
		end else if (seq_restart) begin
			shot_skip_stages <= '0;
		end
	end

	// ****************************************************************
	// broken conductor
	// ****************************************************************
	logic [23:0]            bc_num;
	logic [23:0]            bc_den;
	logic                   bc_ratio_hi;
	logic                   bc_armed;
	logic                   bc_vblock;
	logic                   bc_run;
	logic                   bc_done;
	logic [fpa_pkg::TW-1:0] bc_limit;

	assign bc_num      = 24'(meas_reg.i2) * 24'(fpa_pkg::PCT_SCALE);
	assign bc_den      = 24'(meas_reg.i1) * 24'(bc_ratio_pct);
	assign bc_ratio_hi = bc_num > bc_den;                                        // RULE16
	// below discrimination the ratio is noise; above overcurrent it is meaningful
	assign bc_armed    = i_phase_max >= bc_disc_thr && i_phase_max >= bc_oc_thr; // RULE17
	assign bc_vblock   = meas_reg.v1 < fpa_pkg::clamp16(bc_v1_thr, fpa_pkg::V1_THR_MIN,
		fpa_pkg::V1_THR_MAX) ||                                                   // RULE19
		meas_reg.v0 > fpa_pkg::clamp16(bc_v0_thr, fpa_pkg::V0_THR_MIN,
		fpa_pkg::V0_THR_MAX);                                                     // RULE20
	assign bc_run      = bc_en && bc_armed && bc_ratio_hi && !bc_vblock;
	assign bc_limit    = to_ticks(bc_delay);                                     // RULE18

	fpa_delay_timer u_bc_timer (
		.core_clk (core_clk),
		.rst_b    (rst_b),
		.tick     (tick),
		.run      (bc_run),
		.limit    (bc_limit),
		.done     (bc_done)                               // RULE18
	);

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			bc_out <= '0;
		end else begin
			bc_out.relay <= bc_done && bc_run && bc_route.relay;  // RULE16
			bc_out.virt  <= bc_done && bc_run && bc_route.virt;   // RULE16
		end
	end

endmodule // fpa_prot_aux

// >>> bench/fpa_prot_aux_monitor.sv
/*
 * concurrent checks on the ports of fpa_prot_aux, attached by bind.
 * assumes the single core_clk domain and the active-low rst_b.
 */
module fpa_prot_aux_monitor (
	input wire logic                    core_clk,
	input wire logic                    rst_b,
	input wire logic                    brk_closed,
	input wire logic                    cold_load_pickup_en,
	input wire logic                    cold_load_pickup_block,
	input wire logic                    cold_load_pickup_active,
	input wire logic                    cold_load_pickup_override,
	input wire logic                    cold_load_pickup_curve_sel,
	input wire logic [fpa_pkg::TW-1:0]  cold_load_pickup_delay,
	input wire logic                    cold_load_pickup_stage_reset,
	input wire logic                    bf_en,
	input wire fpa_pkg::fpa_route_t     bf_out,
	input wire logic                    shot_skip_en,
	input wire logic [1:0]              shot_skip_count,
	input wire logic                    shot_skip_trip,
	input wire logic [2:0]              shot_skip_stages,
	input wire logic                    bc_en,
	input wire fpa_pkg::fpa_route_t     bc_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// ****************************************************************
	// checks
	// ****************************************************************
	default clocking mon_cb @(posedge core_clk);
	endclocking
	default disable iff (!rst_b);

	cold_gone_a: assert property (!cold_load_pickup_en |-> ##2 !cold_load_pickup_active)
		else $error("cold load interval runs while disabled");
	cold_start_a: assert property ($rose(cold_load_pickup_active) |->
		$past(brk_closed, 2) && !$past(brk_closed, 3)) else $error("interval without close edge");
	cold_mode_a: assert property (cold_load_pickup_override |->
		cold_load_pickup_active && !cold_load_pickup_curve_sel) else $error("bad override");
	cold_curve_a: assert property (cold_load_pickup_curve_sel |->
		cold_load_pickup_active && !cold_load_pickup_override) else $error("bad curve select");
	blk_delay_a: assert property (cold_load_pickup_block |=>
		cold_load_pickup_delay == '0 && cold_load_pickup_stage_reset) else $error("block ignored");
	blk_free_a: assert property (!cold_load_pickup_block |=> !cold_load_pickup_stage_reset)
		else $error("stage reset without block");
	bf_off_a: assert property (!bf_en |=> bf_out == '0)
		else $error("breaker failure while off");
	skip_off_a: assert property (!shot_skip_en |=> shot_skip_stages == '0 && !shot_skip_trip)
		else $error("shot skip acts while off");
	skip_count_a: assert property ($rose(shot_skip_trip) |->
		shot_skip_stages == 3'((4'h1 << $past(shot_skip_count)) - 4'h1))
		else $error("wrong omitted stages");
	bc_off_a: assert property (!bc_en |=> bc_out == '0)
		else $error("broken conductor while off");

	cover property ($rose(cold_load_pickup_active));
	cover property (bf_out.relay);
	cover property ($rose(shot_skip_trip));
	cover property (bc_out == 2'h3);
endmodule // fpa_prot_aux_monitor

bind fpa_prot_aux fpa_prot_aux_monitor mon (.core_clk, .rst_b, .brk_closed,
	.cold_load_pickup_en, .cold_load_pickup_block, .cold_load_pickup_active,
	.cold_load_pickup_override, .cold_load_pickup_curve_sel, .cold_load_pickup_delay,
	.cold_load_pickup_stage_reset, .bf_en, .bf_out, .shot_skip_en, .shot_skip_count,
	.shot_skip_trip, .shot_skip_stages, .bc_en, .bc_out);

// >>> bench/fpa_front_model.sv
/*
 * measurement front end and breaker status source facing fpa_prot_aux.
 * assumes the bench sets the values it wants and the model strobes them.
 */
module fpa_front_model (
	input  wire logic               core_clk,
	input  wire logic               rst_b,
	input  wire fpa_pkg::fpa_meas_t meas_set,
	input  wire logic               brk_set,
	output fpa_pkg::fpa_meas_t      meas,
	output logic                    meas_valid,
	output logic                    brk_closed
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [1:0] phase_reg;
	logic       brk_mid_reg;

	// ****************************************************************
	// strobed words; between strobes the bus shows garbage on purpose
	// ****************************************************************
	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			phase_reg <= 2'h0;
			meas_valid <= 1'b0;
			meas <= '0;
			brk_mid_reg <= 1'b0;
			brk_closed <= 1'b0;
		end else begin
			phase_reg <= phase_reg + 2'h1;
			meas_valid <= (phase_reg == 2'h3);
			meas <= (phase_reg == 2'h3) ? meas_set : ~meas_set;
			brk_mid_reg <= brk_set;
			brk_closed <= brk_mid_reg;
		end
	end
endmodule // fpa_front_model

// >>> bench/tb.sv
/*
 * self-checking bench for fpa_prot_aux with a shortened tick.
 * assumes fpa_front_model supplies measurements and breaker state.
 */
module tb;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int TICK = 10;
	logic core_clk, rst_b, meas_valid, brk_closed, brk_set, seq_restart;
	logic cold_load_pickup_en, cold_load_pickup_block, cold_load_pickup_active;
	logic cold_load_pickup_override, cold_load_pickup_curve_sel, cold_load_pickup_stage_reset;
	logic bf_en, shot_skip_en, shot_skip_trip, bc_en;
	fpa_pkg::fpa_cold_mode_t cold_load_pickup_mode;
	fpa_pkg::fpa_curve_t    cold_load_pickup_curve, cold_load_pickup_curve_out;
	fpa_pkg::fpa_meas_t     meas, meas_set;
	fpa_pkg::fpa_route_t    bf_route, bf_out, bc_route, bc_out;
	logic [15:0] cold_load_pickup_level, cold_load_pickup_level_out, bf_phase_thr;
	logic [15:0] bf_ground_thr, shot_skip_thr_pp, shot_skip_thr_pg, bc_oc_thr;
	logic [15:0] bc_disc_thr, bc_v1_thr, bc_v0_thr;
	logic [fpa_pkg::TW-1:0] cold_load_pickup_duration, cold_load_pickup_delay, bf_time, bc_delay;
	logic [7:0]  prot_trip, bf_mask, shot_skip_mask, bc_ratio_pct;
	logic [1:0]  shot_skip_count;
	logic [2:0]  shot_skip_stages;
	int bad_count, check_count;
	logic [7:0]  bt [4] = '{8'h04, 8'h08, 8'h01, 8'h04};
	logic [15:0] bib [4] = '{16'h00c8, 16'h0000, 16'h00c8, 16'h0000};
	logic [15:0] bir [4] = '{16'h0000, 16'h003c, 16'h0000, 16'h0028};
	logic [1:0]  brt [4] = '{2'h2, 2'h1, 2'h3, 2'h3};
	logic [1:0]  bx [4] = '{2'h2, 2'h1, 2'h0, 2'h0};
	logic [2:0]  se [4] = '{3'h0, 3'h1, 3'h3, 3'h7};

	fpa_prot_aux #(.TICK_CYCLES(TICK)) uut (.*);
	fpa_front_model fm (.*);

	// ****************************************************************
	// shared tasks
	// ****************************************************************
	task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
		end
	endtask

	task automatic step(int n);
		repeat (n) @(posedge core_clk);
		#1;
	endtask

	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, bad_count);
		if (bad_count == 0 && check_count > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #2 core_clk = ~core_clk;
	end

	// the whole run needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge core_clk);
		bad_count++;
		end_sim();
	end

	// ****************************************************************
	// scenarios
	// ****************************************************************
	initial begin
		rst_b = 1'b0;
		meas_set = '0;
		cold_load_pickup_mode = fpa_pkg::FPA_COLD_PICKUP;
		cold_load_pickup_curve = fpa_pkg::FPA_CURVE_DEFINITE;
		{brk_set, seq_restart, cold_load_pickup_en, cold_load_pickup_block, bf_en, shot_skip_en,
			bc_en, bf_route, bc_route, cold_load_pickup_level, bf_phase_thr, bf_ground_thr,
			shot_skip_thr_pp, shot_skip_thr_pg, bc_oc_thr, bc_disc_thr, bc_v1_thr, bc_v0_thr,
			cold_load_pickup_duration, bf_time, bc_delay, prot_trip, bf_mask, shot_skip_mask,
			bc_ratio_pct, shot_skip_count} = '0;
		step(2);
		rst_b = 1'b1;
		step(1);
		check("reset", {cold_load_pickup_active, cold_load_pickup_override, bf_out, bc_out,
			cold_load_pickup_curve_out, shot_skip_trip, shot_skip_stages}, 32'h0);
		cold_load_pickup_en = 1'b1;
		cold_load_pickup_level = 16'h0123;
		cold_load_pickup_duration = 10'h003;
		step(2);
		check("cold_delay", cold_load_pickup_delay, 32'h3);
		brk_set = 1'b1;
		step(15);
		check("cold_pick", {cold_load_pickup_active, cold_load_pickup_override,
			cold_load_pickup_curve_sel, cold_load_pickup_level_out}, {3'h6, 16'h0123});
		step(35);
		check("cold_end", cold_load_pickup_active, 32'h0);
		cold_load_pickup_mode = fpa_pkg::FPA_COLD_CURVE;
		for (int c = 0; c < 2; c++) begin
			brk_set = 1'b0;
			cold_load_pickup_curve = fpa_pkg::fpa_curve_t'(c);
			step(5);
			brk_set = 1'b1;
			step(10);
			check("cold_curve", {cold_load_pickup_active, cold_load_pickup_override,
				cold_load_pickup_curve_sel, cold_load_pickup_curve_out}, {3'h5, 1'(c)});
		end
		brk_set = 1'b0;
		step(6);
		check("cold_open", cold_load_pickup_active, 32'h0);
		cold_load_pickup_en = 1'b0;
		brk_set = 1'b1;
		step(8);
		cold_load_pickup_en = 1'b1;
		step(8);
		check("cold_off", cold_load_pickup_active, 32'h0);
		brk_set = 1'b0;
		cold_load_pickup_block = 1'b1;
		step(5);
		brk_set = 1'b1;
		step(8);
		check("cold_blk", {cold_load_pickup_active, cold_load_pickup_delay,
			cold_load_pickup_stage_reset}, {1'b0, 10'h000, 1'b1});
		cold_load_pickup_block = 1'b0;
		brk_set = 1'b0;
		bf_en = 1'b1;
		bf_mask = 8'h0c;
		bf_phase_thr = 16'h0064;
		bf_ground_thr = 16'h0032;
		bf_time = 10'h003;
		for (int k = 0; k < 4; k++) begin
			meas_set = '0;
			meas_set.i_a = 16'h00c8;
			meas_set.i_b = bib[k];
			meas_set.i_res = bir[k];
			bf_route = bx[k] | brt[k];
			prot_trip = bt[k];
			step(12);
			check("bf_early", bf_out, 32'h0);
			step(35);
			check("bf_out", bf_out, {30'h0, bx[k]});
			prot_trip = 8'h00;
			step(2);
			check("bf_drop", bf_out, 32'h0);
		end
		shot_skip_en = 1'b1;
		shot_skip_mask = 8'h02;
		// 100 A sits below the settable floor, so the 300 A case must not fire
		shot_skip_thr_pp = 16'h0064;
		shot_skip_thr_pg = 16'h0258;
		for (int k = 0; k < 6; k++) begin
			meas_set = '0;
			meas_set.i_a = (k == 4) ? 16'h012c : (k[0] && k < 4) ? 16'h0000 : 16'h05dc;
			meas_set.i_res = (k[0] && k < 4) ? 16'h02bc : 16'h0000;
			shot_skip_count = k[1:0];
			seq_restart = (k < 4);
			step(1);
			seq_restart = 1'b0;
			prot_trip = (k == 5) ? 8'h01 : 8'h02;
			step(8);
			check("skip_trip", shot_skip_trip, {31'h0, k < 4});
			if (k < 4)
				check("skip_stages", shot_skip_stages, {29'h0, se[k]});
			prot_trip = 8'h00;
			step(3);
		end
		shot_skip_en = 1'b0;
		step(2);
		check("skip_off", shot_skip_stages, 32'h0);
		bc_en = 1'b1;
		bc_oc_thr = 16'h0064;
		bc_disc_thr = 16'h0032;
		bc_ratio_pct = 8'h14;
		bc_delay = 10'h003;
		bc_v1_thr = 16'h0032;
		bc_v0_thr = 16'h0014;
		for (int k = 0; k < 6; k++) begin
			meas_set = '0;
			meas_set.i_a = (k == 4) ? 16'h0028 : ((k == 5) ? 16'h0050 : 16'h00c8);
			meas_set.i1 = 16'h0064;
			meas_set.i2 = (k == 1) ? 16'h0014 : 16'h001e;
			meas_set.v1 = (k == 2) ? 16'h0028 : 16'h0050;
			meas_set.v0 = (k == 3) ? 16'h001e : 16'h000a;
			bc_route = (k == 0) ? 2'h3 : 2'h1;
			if (k == 0) begin
				step(12);
				check("bc_early", bc_out, 32'h0);
			end
			step(40);
			check("bc_out", bc_out, (k == 0) ? 32'h3 : 32'h0);
		end
		end_sim();
	end
endmodule // tb
